// ---- shared/ljt_pkg.sv ----
// register map, field layout and reset values of the lock threshold and tx irq mask slice
package ljt_pkg;
   localparam int unsigned ADDR_W   = 8;
   localparam int unsigned DATA_W   = 8;
   localparam int unsigned THR_W    = 14;
   localparam int unsigned SRC_N    = 7;

   // register offsets
   localparam logic [7:0] OFF_THR_LOW  = 8'h6b;
   localparam logic [7:0] OFF_THR_MID  = 8'h6c;
   localparam logic [7:0] OFF_THR_HIGH = 8'h6d;
   localparam logic [7:0] OFF_TX_CFG2  = 8'h83;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h84;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h85;
   localparam logic [7:0] OFF_CTRL     = 8'h86;

   // reset values
   localparam logic [7:0] RST_THR      = 8'h00;
   localparam logic [7:0] RST_TX_CFG2  = 8'h22;
   localparam logic [7:0] RST_MASK     = 8'h00;
   localparam logic [7:0] RST_CTRL     = 8'h00;

   // field positions
   localparam int unsigned THR_LOW_BIT  = 7;
   localparam int unsigned THR_HIGH_W   = 5;
   localparam int unsigned CFG2_PDN_BIT = 0;
   localparam int unsigned CFG2_TOP_BIT = 7;
   localparam int unsigned FIFO_BIT     = 3;
   localparam int unsigned CTRL_IEN_BIT = 0;
   localparam int unsigned CTRL_AUTO_BIT = 1;
   localparam logic [7:0] UNMAPPED_RD  = 8'h00;
endpackage

// ---- rtl/ljt_sticky_bit.sv ----
// one sticky alarm bit: set by its source, cleared by software
`timescale 1ns/100ps
module ljt_sticky_bit (
   // clocking
   input  wire logic core_clk,
   input  wire logic sys_rst,
   input  wire logic clk_en,
   // control
   input  wire logic set_in,
   input  wire logic clr_in,
   // state
   output logic      flag_r
);
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         flag_r <= 1'b0;
      end else if (clk_en) begin
         // a set in the clearing cycle wins
         if (set_in) begin
            flag_r <= 1'b1;
         end else if (clr_in) begin
            flag_r <= 1'b0;
         end
      end
   end
endmodule // ljt_sticky_bit

// ---- rtl/ljt_regs.sv ----
// What this block does
// - threshold fourteen bits, lsb in low bit7
// - lock loss above threshold, cleared below
// - threshold bits eight to one in mid
// - threshold bits thirteen to nine in high
// - config bit0 powers down tx, bit7 zero
// - mask bit per alarm source, bit7 zero
// - clear mask bit lets source interrupt
// - fifo mask reads zero under auto-recover
// - sticky alarm bits, cleared by zero or disable
`timescale 1ns/100ps
module ljt_regs (
   // clocking
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic        clk_en,
   // register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // monitor and alarms
   input  wire logic [13:0] jitter_measure,
   input  wire logic [6:0]  alarm_src,
   // outputs
   output logic             rx_lock_loss,
   output logic             tx_power_down,
   output logic             irq_out
);
   logic [7:0]  thr_low_r;
   logic [7:0]  thr_mid_r;
   logic [7:0]  thr_high_r;
   logic [7:0]  cfg2_r;
   logic [7:0]  mask_r;
   logic [7:0]  ctrl_r;
   logic [13:0] jitter_lock_threshold;
   logic [6:0]  sticky;
   logic [6:0]  stat_set;
   logic [6:0]  stat_clr;
   logic        irq_global_enable;
   logic        fifo_auto_recover;
   logic        rx_lock_loss_nxt;
   logic [7:0]  rdata_nxt;
   logic [7:0]  mask_view;

   assign irq_global_enable = ctrl_r[ljt_pkg::CTRL_IEN_BIT];
   assign fifo_auto_recover = ctrl_r[ljt_pkg::CTRL_AUTO_BIT];

   // assemble the threshold from its three registers
   assign jitter_lock_threshold = {thr_high_r[ljt_pkg::THR_HIGH_W-1:0], thr_mid_r,
                                   thr_low_r[ljt_pkg::THR_LOW_BIT]};

   // threshold registers
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         thr_low_r  <= ljt_pkg::RST_THR;
         thr_mid_r  <= ljt_pkg::RST_THR;
         thr_high_r <= ljt_pkg::RST_THR;
      end else if (clk_en && reg_wr) begin
         if (reg_addr == ljt_pkg::OFF_THR_LOW) begin
            thr_low_r <= reg_wdata;
         end
         if (reg_addr == ljt_pkg::OFF_THR_MID) begin
            thr_mid_r <= reg_wdata;
         end
         if (reg_addr == ljt_pkg::OFF_THR_HIGH) begin
            thr_high_r <= reg_wdata;
         end
      end
   end

   // tx config and mask; bit7 of each is never stored
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cfg2_r <= ljt_pkg::RST_TX_CFG2;
         mask_r <= ljt_pkg::RST_MASK;
      end else if (clk_en && reg_wr) begin
         if (reg_addr == ljt_pkg::OFF_TX_CFG2) begin
            cfg2_r <= {1'b0, reg_wdata[6:0]};
         end
         if (reg_addr == ljt_pkg::OFF_IRQ_MASK) begin
            mask_r <= {1'b0, reg_wdata[6:0]};
         end
      end
   end

   // global control: irq enable and fifo auto-recover
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ctrl_r <= ljt_pkg::RST_CTRL;
      end else if (clk_en && reg_wr && reg_addr == ljt_pkg::OFF_CTRL) begin
         ctrl_r <= {6'h00, reg_wdata[1:0]};
      end
   end

   assign tx_power_down = cfg2_r[ljt_pkg::CFG2_PDN_BIT];

   // lock loss with hysteresis-free compare: equal keeps the old state
   always_comb begin
      rx_lock_loss_nxt = rx_lock_loss;
      if (jitter_measure > jitter_lock_threshold) begin
         rx_lock_loss_nxt = 1'b1;
      end else if (jitter_measure < jitter_lock_threshold) begin
         rx_lock_loss_nxt = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rx_lock_loss <= 1'b0;
      end else if (clk_en) begin
         rx_lock_loss <= rx_lock_loss_nxt;
      end
   end

   // sticky status: writing zero clears, disabling irq clears all bits whose alarm is not active
   assign stat_set = alarm_src;
   assign stat_clr = ({7{reg_wr && reg_addr == ljt_pkg::OFF_IRQ_STAT}} & ~reg_wdata[6:0])
                     | {7{~irq_global_enable}};

   genvar gi;
   generate
      for (gi = 0; gi < ljt_pkg::SRC_N; gi++) begin : g_stat
         ljt_sticky_bit u_bit (
            .core_clk (core_clk),
            .sys_rst  (sys_rst),
            .clk_en   (clk_en),
            .set_in   (stat_set[gi]),
            .clr_in   (stat_clr[gi]),
            .flag_r   (sticky[gi])
         );
      end
   endgenerate

   // level irq from unmasked latched alarms
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         irq_out <= 1'b0;
      end else if (clk_en) begin
         irq_out <= irq_global_enable && |(sticky & ~mask_r[6:0]);
      end
   end

   // mask readback hides the fifo bit under auto-recover
   always_comb begin
      mask_view = mask_r;
      if (fifo_auto_recover) begin
         mask_view[ljt_pkg::FIFO_BIT] = 1'b0;
      end
   end

   always_comb begin
      unique case (reg_addr)
         ljt_pkg::OFF_THR_LOW:  rdata_nxt = thr_low_r;
         ljt_pkg::OFF_THR_MID:  rdata_nxt = thr_mid_r;
         ljt_pkg::OFF_THR_HIGH: rdata_nxt = thr_high_r;
         ljt_pkg::OFF_TX_CFG2:  rdata_nxt = cfg2_r;
         ljt_pkg::OFF_IRQ_MASK: rdata_nxt = mask_view;
         ljt_pkg::OFF_IRQ_STAT: rdata_nxt = {1'b0, sticky};
         ljt_pkg::OFF_CTRL:     rdata_nxt = ctrl_r;
         default:               rdata_nxt = ljt_pkg::UNMAPPED_RD;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (clk_en && reg_rd) begin
         reg_rdata <= rdata_nxt;
      end
   end

   // assertions
   a_lol_sets_above: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && jitter_measure > jitter_lock_threshold |=> rx_lock_loss)
      else $error("lock loss not set above threshold");
   a_lol_clears_below: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && jitter_measure < jitter_lock_threshold |=> !rx_lock_loss)
      else $error("lock loss not cleared below threshold");
   a_irq_needs_enable: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && !irq_global_enable |=> !irq_out)
      else $error("irq raised while disabled");
   a_irq_follows_stat: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && irq_global_enable && (sticky & ~mask_r[6:0]) != 7'h00 |=> irq_out)
      else $error("irq missing for unmasked alarm");
   a_sticky_holds: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && alarm_src[0] |=> sticky[0])
      else $error("alarm not latched");
   a_fifo_mask_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && reg_rd && reg_addr == ljt_pkg::OFF_IRQ_MASK && fifo_auto_recover
      |=> !reg_rdata[ljt_pkg::FIFO_BIT])
      else $error("fifo mask read nonzero under auto-recover");
   a_cfg_top_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && reg_rd && reg_addr == ljt_pkg::OFF_TX_CFG2 |=> !reg_rdata[7])
      else $error("config bit7 read nonzero");
   a_pdn_write: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && reg_wr && reg_addr == ljt_pkg::OFF_TX_CFG2
      |=> tx_power_down == $past(reg_wdata[0]))
      else $error("power down not taken from write");
   a_thr_mid_map: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && reg_wr && reg_addr == ljt_pkg::OFF_THR_MID
      |=> jitter_lock_threshold[8:1] == $past(reg_wdata))
      else $error("threshold mid bits wrong");
   a_thr_high_map: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && reg_wr && reg_addr == ljt_pkg::OFF_THR_HIGH
      |=> jitter_lock_threshold[13:9] == $past(reg_wdata[4:0]))
      else $error("threshold high bits wrong");
   a_reset_cfg: assert property (@(posedge core_clk)
      sys_rst |=> cfg2_r == ljt_pkg::RST_TX_CFG2 && mask_r == ljt_pkg::RST_MASK)
      else $error("reset values wrong");

   // threshold storage and readback
   a_thr_low_map: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && reg_wr && reg_addr == ljt_pkg::OFF_THR_LOW
      |=> jitter_lock_threshold[0] == $past(reg_wdata[ljt_pkg::THR_LOW_BIT]))
      else $error("threshold low bit wrong");
   a_thr_low_keep: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && reg_wr && reg_addr == ljt_pkg::OFF_THR_LOW
      |=> thr_low_r == $past(reg_wdata))
      else $error("threshold low register not stored");
   a_thr_mid_keep: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && reg_wr && reg_addr == ljt_pkg::OFF_THR_MID
      |=> thr_mid_r == $past(reg_wdata))
      else $error("threshold mid register not stored");
   a_thr_high_keep: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && reg_wr && reg_addr == ljt_pkg::OFF_THR_HIGH
      |=> thr_high_r == $past(reg_wdata))
      else $error("threshold high register not stored");
   a_thr_low_read: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && reg_rd && reg_addr == ljt_pkg::OFF_THR_LOW
      |=> reg_rdata == $past(thr_low_r))
      else $error("threshold low readback wrong");
   a_thr_mid_read: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && reg_rd && reg_addr == ljt_pkg::OFF_THR_MID
      |=> reg_rdata == $past(thr_mid_r))
      else $error("threshold mid readback wrong");
   a_thr_high_read: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && reg_rd && reg_addr == ljt_pkg::OFF_THR_HIGH
      |=> reg_rdata == $past(thr_high_r))
      else $error("threshold high readback wrong");

   // lock indication
   a_lol_equal_holds: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && jitter_measure == jitter_lock_threshold
      |=> rx_lock_loss == $past(rx_lock_loss))
      else $error("lock loss moved at equal jitter");
   a_lol_frozen: assert property (@(posedge core_clk) disable iff (sys_rst)
      !clk_en
      |=> $stable(rx_lock_loss))
      else $error("lock loss moved while frozen");

   // tx config
   a_cfg_write_keep: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && reg_wr && reg_addr == ljt_pkg::OFF_TX_CFG2
      |=> cfg2_r[6:1] == $past(reg_wdata[6:1]))
      else $error("config middle bits not stored");
   a_cfg_read: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && reg_rd && reg_addr == ljt_pkg::OFF_TX_CFG2
      |=> reg_rdata == $past(cfg2_r))
      else $error("config readback wrong");
   a_top_bits_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
      !mask_r[ljt_pkg::SRC_N]
      && !cfg2_r[ljt_pkg::CFG2_TOP_BIT])
      else $error("top bit stored");

   // interrupt mask
   a_mask_write: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && reg_wr && reg_addr == ljt_pkg::OFF_IRQ_MASK
      |=> mask_r[6:0] == $past(reg_wdata[6:0]))
      else $error("mask not stored");
   a_mask_read: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && reg_rd && reg_addr == ljt_pkg::OFF_IRQ_MASK && !fifo_auto_recover
      |=> reg_rdata == $past(mask_r))
      else $error("mask readback wrong");
   a_mask_read_top: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && reg_rd && reg_addr == ljt_pkg::OFF_IRQ_MASK
      |=> !reg_rdata[ljt_pkg::SRC_N])
      else $error("mask bit7 read nonzero");
   a_fifo_mask_rest: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && reg_rd && reg_addr == ljt_pkg::OFF_IRQ_MASK && fifo_auto_recover
      |=> reg_rdata[6:4] == $past(mask_r[6:4]) && reg_rdata[2:0] == $past(mask_r[2:0]))
      else $error("other mask bits hidden under auto-recover");

   // interrupt output
   a_irq_masked_off: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && (sticky & ~mask_r[6:0]) == 7'h00
      |=> !irq_out)
      else $error("irq raised with all alarms masked");
   a_irq_frozen: assert property (@(posedge core_clk) disable iff (sys_rst)
      !clk_en
      |=> $stable(irq_out))
      else $error("irq moved while frozen");

   // sticky status
   a_stat_clear_write: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && reg_wr && reg_addr == ljt_pkg::OFF_IRQ_STAT && !reg_wdata[0] && !alarm_src[0]
      |=> !sticky[0])
      else $error("status not cleared by zero write");
   a_stat_clear_dis: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && !irq_global_enable && !alarm_src[0]
      |=> !sticky[0])
      else $error("status not cleared while disabled");
   a_stat_write_one: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && reg_wr && reg_addr == ljt_pkg::OFF_IRQ_STAT && reg_wdata[0] && sticky[0]
      && irq_global_enable |=> sticky[0])
      else $error("status cleared by one write");
   a_sticky_top: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && alarm_src[6]
      |=> sticky[6])
      else $error("top alarm not latched");
   a_stat_read: assert property (@(posedge core_clk) disable iff (sys_rst)
      clk_en && reg_rd && reg_addr == ljt_pkg::OFF_IRQ_STAT
      |=> reg_rdata == {1'b0, $past(sticky)})
      else $error("status readback wrong");

   // register port and freeze
   a_rdata_holds: assert property (@(posedge core_clk) disable iff (sys_rst)
      !(clk_en && reg_rd)
      |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   a_regs_frozen: assert property (@(posedge core_clk) disable iff (sys_rst)
      !clk_en
      |=> $stable(thr_low_r) && $stable(cfg2_r) && $stable(mask_r))
      else $error("register moved while frozen");

   // reset values
   a_reset_thr: assert property (@(posedge core_clk)
      sys_rst
      |=> thr_low_r == ljt_pkg::RST_THR && thr_mid_r == ljt_pkg::RST_THR && thr_high_r == ljt_pkg::RST_THR)
      else $error("threshold reset wrong");
   a_reset_outs: assert property (@(posedge core_clk)
      sys_rst
      |=> !rx_lock_loss && !irq_out && !tx_power_down)
      else $error("outputs not idle after reset");
   a_reset_ctrl: assert property (@(posedge core_clk)
      sys_rst
      |=> ctrl_r == ljt_pkg::RST_CTRL && sticky == 7'h00)
      else $error("control or status reset wrong");
endmodule // ljt_regs

// ---- dv/ljt_regs_tb_top.sv ----
// self-checking bench for the lock threshold and tx irq mask register slice
`timescale 1ns/100ps
module ljt_regs_tb_top;
   logic        core_clk;
   logic        sys_rst;
   logic        clk_en;
   logic [7:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_rdata;
   logic [13:0] jitter_measure;
   logic [6:0]  alarm_src;
   logic        rx_lock_loss;
   logic        tx_power_down;
   logic        irq_out;
   int          n_fail;
   int          checks_done;
   int          cycles;
   integer      seed;
   logic [13:0] thr;
   logic [7:0]  m;

   ljt_regs dut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .jitter_measure(jitter_measure), .alarm_src(alarm_src),
      .rx_lock_loss(rx_lock_loss), .tx_power_down(tx_power_down), .irq_out(irq_out));

   always #2 core_clk = ~core_clk;

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic results;
      if (n_fail == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic wait_n(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
      // let the write settle before anyone looks at the outputs
      #1;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      #1;
      chk(what, exp, reg_rdata);
   endtask

   // drive a jitter value and look at the lock indication once it has settled
   task automatic lock(input logic [13:0] j, input logic exp);
      @(posedge core_clk);
      jitter_measure <= j;
      wait_n(2);
      chk("rx_lock_loss", {7'h00, exp}, {7'h00, rx_lock_loss});
   endtask

   task automatic pulse(input int i);
      @(posedge core_clk);
      alarm_src <= 7'(1 << i);
      @(posedge core_clk);
      alarm_src <= 7'h00;
      wait_n(3);
   endtask

   function automatic logic [7:0] irqv;
      return {7'h00, irq_out};
   endfunction

   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_fail++;
         results();
      end
   end

   initial begin
      core_clk = 1'b0;
      sys_rst = 1'b1;
      clk_en = 1'b1;
      {reg_addr, reg_wdata, reg_wr, reg_rd, alarm_src} = '0;
      jitter_measure = 14'h0000;
      {n_fail, checks_done, cycles} = '0;
      seed = 81;
      repeat (10) @(posedge core_clk);
      sys_rst <= 1'b0;
      rd(ljt_pkg::OFF_THR_LOW, ljt_pkg::RST_THR, "thr_low");
      rd(ljt_pkg::OFF_THR_MID, ljt_pkg::RST_THR, "thr_mid");
      rd(ljt_pkg::OFF_THR_HIGH, ljt_pkg::RST_THR, "thr_high");
      rd(ljt_pkg::OFF_TX_CFG2, ljt_pkg::RST_TX_CFG2, "cfg2");
      rd(ljt_pkg::OFF_IRQ_MASK, ljt_pkg::RST_MASK, "mask");
      chk("tx_power_down", 8'h00, {7'h00, tx_power_down});
      rd(8'h90, ljt_pkg::UNMAPPED_RD, "unmapped");
      wr(ljt_pkg::OFF_TX_CFG2, 8'ha3);
      rd(ljt_pkg::OFF_TX_CFG2, 8'h23, "cfg2");
      chk("tx_power_down", 8'h01, {7'h00, tx_power_down});
      wr(ljt_pkg::OFF_TX_CFG2, 8'h22);
      chk("tx_power_down", 8'h00, {7'h00, tx_power_down});
      // a strobe while the clock enable is low must be dropped
      @(posedge core_clk);
      clk_en <= 1'b0;
      wr(ljt_pkg::OFF_IRQ_MASK, 8'h7f);
      clk_en <= 1'b1;
      rd(ljt_pkg::OFF_IRQ_MASK, 8'h00, "mask_frozen");
      for (int k = 0; k < 14; k++) begin
         thr = (k == 0) ? 14'h3ffe : (k == 1) ? 14'h0001 : 14'($random(seed));
         if (thr == 14'h0000 || thr == 14'h3fff) thr = 14'h2001;
         wr(ljt_pkg::OFF_THR_LOW, {thr[0], 7'b010_0000});
         wr(ljt_pkg::OFF_THR_MID, thr[8:1]);
         wr(ljt_pkg::OFF_THR_HIGH, {3'b101, thr[13:9]});
         rd(ljt_pkg::OFF_THR_LOW, {thr[0], 7'h20}, "thr_low");
         rd(ljt_pkg::OFF_THR_MID, thr[8:1], "thr_mid");
         rd(ljt_pkg::OFF_THR_HIGH, {3'b101, thr[13:9]}, "thr_high");
         lock(thr + 14'h0001, 1'b1);
         lock(thr, 1'b1);
         lock(thr - 14'h0001, 1'b0);
         lock(thr, 1'b0);
      end
      repeat (6) begin
         m = 8'($random(seed));
         wr(ljt_pkg::OFF_IRQ_MASK, m);
         rd(ljt_pkg::OFF_IRQ_MASK, m & 8'h7f, "mask");
         wr(ljt_pkg::OFF_CTRL, 8'h02);
         rd(ljt_pkg::OFF_IRQ_MASK, m & 8'h77, "mask_auto");
         wr(ljt_pkg::OFF_CTRL, 8'h00);
      end
      for (int i = 0; i < 7; i++) begin
         wr(ljt_pkg::OFF_CTRL, 8'h01);
         wr(ljt_pkg::OFF_IRQ_MASK, 8'h00);
         pulse(i);
         chk("irq_unmasked", 8'h01, irqv());
         wr(ljt_pkg::OFF_IRQ_STAT, 8'h7f);
         rd(ljt_pkg::OFF_IRQ_STAT, 8'(1 << i), "status");
         wr(ljt_pkg::OFF_IRQ_STAT, 8'h00);
         wait_n(2);
         chk("irq_cleared", 8'h00, irqv());
         wr(ljt_pkg::OFF_IRQ_MASK, 8'(1 << i));
         pulse(i);
         chk("irq_masked", 8'h00, irqv());
         rd(ljt_pkg::OFF_IRQ_STAT, 8'(1 << i), "status_masked");
         wr(ljt_pkg::OFF_IRQ_MASK, 8'h00);
         wait_n(2);
         chk("irq_unmask", 8'h01, irqv());
         wr(ljt_pkg::OFF_CTRL, 8'h00);
         wait_n(2);
         chk("irq_disabled", 8'h00, irqv());
         rd(ljt_pkg::OFF_IRQ_STAT, 8'h00, "status_disabled");
      end
      // a second reset in mid-run must restore the reset values
      @(posedge core_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      rd(ljt_pkg::OFF_THR_HIGH, ljt_pkg::RST_THR, "thr_high_rerst");
      rd(ljt_pkg::OFF_TX_CFG2, ljt_pkg::RST_TX_CFG2, "cfg2_rerst");
      results();
   end
endmodule // ljt_regs_tb_top
